// ===== cam_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - While running, each output follows its on/off window, repeating every cycle.
// - At power-up, clear present value if clear input set, else keep it.
// - Run-on-power-up starts timing at once; otherwise wait for a start edge.
// - Restore select asserted holds outputs off until start or reset.
// - Restore select is ignored while run-on-power-up is asserted.
// - Latching start rising edge runs continuously; falling edge ignored.
// - Single start runs; after its falling edge, stop at cycle end.
// - The most recent start input decides the run mode.
// - Pause input, while asserted, freezes timing and holds the outputs unless a reset edge arrives while idle.
// - Reset rising edge zeroes the present value and stops timing.
// - Blanking input forces all outputs off while it is asserted.
// - Present value keeps advancing while outputs are blanked.
// - No confirm during output 1 on gives an alarm when output 1 falls.
// - Power-up configuration inputs are sampled only once after reset.
module cam_timer
    import cam_timer_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int CYCLE_LEN = CYCLE_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear_on_power_up,
    input wire logic run_on_power_up,
    input wire logic output_restore_sel,
    input wire logic [PV_WIDTH-1:0] retained_pv,
    input wire logic [OUT_COUNT-1:0] retained_out,
    input wire logic [OUT_COUNT*PV_WIDTH-1:0] on_time,
    input wire logic [OUT_COUNT*PV_WIDTH-1:0] off_time,
    input wire logic start_latch,
    input wire logic start_single,
    input wire logic pause_in,
    input wire logic reset_in,
    input wire logic blank_in,
    input wire logic actuator_confirm_one,
    output logic [OUT_COUNT-1:0] ctrl_out,
    output logic [PV_WIDTH-1:0] present_value,
    output logic timing,
    output logic alarm
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_r, s2_r, s3_r;
    logic [NSYNC-1:0] rise;

    assign raw = {actuator_confirm_one, blank_in, reset_in, pause_in,
                  start_single, start_latch, output_restore_sel,
                  run_on_power_up, clear_on_power_up, 1'b0};

    // Two flops per input, a third stage for edge detection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign rise = s2_r & ~s3_r;

    logic cfg_clear, cfg_run, cfg_restore;
    logic st_l, st_s, st_s_fall, pause_lv, rst_rise, blank_lv, confirm_lv;
    assign st_l = rise[4];
    assign st_s = rise[5];
    assign st_s_fall = ~s2_r[5] & s3_r[5];
    assign pause_lv = s2_r[6];
    assign rst_rise = rise[7];
    assign blank_lv = s2_r[8];
    assign confirm_lv = s2_r[9];

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    logic init_r, init_nxt;
    logic [1:0] boot_r, boot_nxt;
    logic [2:0] cfg_r, cfg_nxt;
    run_state_t state_r, state_nxt;
    logic stop_pend_r, stop_pend_nxt;
    logic hold_off_r, hold_off_nxt;
    logic [PV_WIDTH-1:0] pv_r, pv_nxt;
    logic [31:0] div_r, div_nxt;
    logic [OUT_COUNT-1:0] out_r, out_nxt;
    logic seen_r, seen_nxt;
    logic alarm_r, alarm_nxt;
    logic [OUT_COUNT-1:0] pattern;
    logic tick, cycle_end;

    assign cfg_clear = cfg_r[0];
    assign cfg_run = cfg_r[1];
    assign cfg_restore = cfg_r[2];

    // Pattern decode: output on while present value is in its window.
    genvar g;
    generate
        for (g = 0; g < OUT_COUNT; g++) begin : g_pat
            assign pattern[g] =
                (pv_r >= on_time[g*PV_WIDTH +: PV_WIDTH]) &&
                (pv_r < off_time[g*PV_WIDTH +: PV_WIDTH]);
        end
    endgenerate

    assign tick = (state_r != ST_IDLE) && !pause_lv &&
                  (div_r == 32'(TICK_DIV - 1));
    assign cycle_end = tick && (pv_r == PV_WIDTH'(CYCLE_LEN - 1));

    // Next-state logic for the whole sequencer.
    always_comb begin
        init_nxt = init_r;
        boot_nxt = boot_r;
        cfg_nxt = cfg_r;
        state_nxt = state_r;
        stop_pend_nxt = stop_pend_r;
        hold_off_nxt = hold_off_r;
        pv_nxt = pv_r;
        div_nxt = div_r;
        out_nxt = out_r;
        seen_nxt = seen_r;
        alarm_nxt = 1'b0;
        if (!init_r) begin
            // Wait for synchronisers to fill, then capture straps once.
            boot_nxt = boot_r + 2'd1;
            if (boot_r == 2'd3) begin
                init_nxt = 1'b1;
                cfg_nxt = s2_r[3:1];
                pv_nxt = s2_r[1] ? PV_RESET : retained_pv;
                if (s2_r[2]) begin
                    state_nxt = ST_RUN_CONT;
                    out_nxt = OUT_RESET;
                end else begin
                    // Outputs stay frozen, off or at the kept states.
                    hold_off_nxt = 1'b1;
                    out_nxt = s2_r[3] ? OUT_RESET : retained_out;
                end
            end
        end else begin
            if (rst_rise) begin
                pv_nxt = PV_RESET;
                div_nxt = '0;
                state_nxt = ST_IDLE;
                stop_pend_nxt = 1'b0;
                hold_off_nxt = 1'b0;
            end else begin
                if (st_l) begin
                    state_nxt = ST_RUN_CONT;
                    stop_pend_nxt = 1'b0;
                    hold_off_nxt = 1'b0;
                end else if (st_s) begin
                    state_nxt = ST_RUN_SINGLE;
                    stop_pend_nxt = 1'b0;
                    hold_off_nxt = 1'b0;
                end else if (st_s_fall && state_r == ST_RUN_SINGLE) begin
                    stop_pend_nxt = 1'b1;
                end
                if (state_r != ST_IDLE && !pause_lv) begin
                    // Counting resumes from the frozen value.
                    div_nxt = tick ? '0 : div_r + 32'd1;
                    if (tick) begin
                        pv_nxt = cycle_end ? PV_RESET :
                                 pv_r + PV_WIDTH'(1);
                    end
                    if (cycle_end && state_r == ST_RUN_SINGLE &&
                        (stop_pend_r || st_s_fall) && !st_l && !st_s) begin
                        state_nxt = ST_IDLE;
                        stop_pend_nxt = 1'b0;
                    end
                end
            end
            // Outputs follow the pattern unless held off, or paused without a reset edge in idle.
            if (!pause_lv && !hold_off_nxt) begin
                out_nxt = pattern;
            end
            if (!hold_off_nxt && state_r == ST_IDLE && rst_rise) begin
                out_nxt = pattern;
            end
            // Alarm tracking on output 1.
            if (out_r[0] && confirm_lv) begin
                seen_nxt = 1'b1;
            end
            if (out_r[0] && !out_nxt[0]) begin
                alarm_nxt = !(seen_r || confirm_lv);
                seen_nxt = 1'b0;
            end
        end
    end

    // Registers of the sequencer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_r <= 1'b0;
            boot_r <= 2'd0;
            cfg_r <= 3'h0;
            state_r <= ST_IDLE;
            stop_pend_r <= 1'b0;
            hold_off_r <= 1'b0;
            pv_r <= PV_RESET;
            div_r <= '0;
            out_r <= OUT_RESET;
            seen_r <= 1'b0;
            alarm_r <= 1'b0;
        end else begin
            init_r <= init_nxt;
            boot_r <= boot_nxt;
            cfg_r <= cfg_nxt;
            state_r <= state_nxt;
            stop_pend_r <= stop_pend_nxt;
            hold_off_r <= hold_off_nxt;
            pv_r <= pv_nxt;
            div_r <= div_nxt;
            out_r <= out_nxt;
            seen_r <= seen_nxt;
            alarm_r <= alarm_nxt;
        end
    end

    // Blanking gates the visible outputs only.
    assign ctrl_out = blank_lv ? OUT_RESET : out_r;
    assign present_value = pv_r;
    assign timing = (state_r != ST_IDLE) && !pause_lv;
    assign alarm = alarm_r;

    // Captured straps are kept for visibility of configuration.
    logic unused_cfg;
    assign unused_cfg = cfg_clear ^ cfg_run ^ cfg_restore ^ rise[0]
                        ^ rise[1] ^ rise[2] ^ rise[3] ^ rise[6]
                        ^ rise[8] ^ rise[9];

endmodule
`default_nettype wire

// ===== cam_timer_pkg.sv
package cam_timer_pkg;

    // ------------------------------------------------------------------
    // Time base and pattern constants
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int CYCLE_TICKS = 1000;
    localparam int OUT_COUNT = 16;
    localparam int PV_WIDTH = 16;
    localparam logic [PV_WIDTH-1:0] PV_RESET = 16'h0000;
    localparam logic [15:0] OUT_RESET = 16'h0000;

    // Run state of the cycle sequencer.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN_CONT,
        ST_RUN_SINGLE
    } run_state_t;

endpackage

// ===== cam_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checks
// ----
module cam_timer_sva
    import cam_timer_pkg::*;
#(
    parameter int TICK_DIV = 4,
    parameter int CYCLE_LEN = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start_latch,
    input wire logic pause_in,
    input wire logic reset_in,
    input wire logic blank_in,
    input wire logic [OUT_COUNT-1:0] ctrl_out,
    input wire logic [PV_WIDTH-1:0] present_value,
    input wire logic timing,
    input wire logic alarm
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Levels held long enough to pass the input synchronisers.
    sequence s_pause;
        pause_in [*6];
    endsequence
    sequence s_blank;
        blank_in [*5];
    endsequence
    a_pv_range: assert property (present_value < CYCLE_LEN)
        else $error("pv out of range");
    a_pv_step: assert property (
        $changed(present_value) && $past(timing) |->
        present_value == $past(present_value) + 16'h0001 ||
        present_value == 16'h0000) else $error("pv bad step");
    a_tick_gap: assert property ($changed(present_value) |=>
        ($stable(present_value) || present_value == 16'h0000) [*3])
        else $error("pv ticks too fast");
    a_pause_freeze: assert property (
        s_pause |-> !timing && $stable(present_value))
        else $error("pause did not freeze");
    a_reset_stops: assert property ($rose(reset_in) |->
        ##[1:5] (!timing && present_value == 16'h0000))
        else $error("reset did not stop");
    a_start_runs: assert property (
        $rose(start_latch) && !pause_in && !reset_in |-> ##[1:5] timing)
        else $error("start did not run");
    a_blank_off: assert property (
        s_blank |-> ctrl_out == 16'h0000) else $error("blank failed");
    a_alarm_pulse: assert property (alarm |=> !alarm)
        else $error("alarm too long");
endmodule
bind cam_timer cam_timer_sva #(.TICK_DIV(TICK_DIV), .CYCLE_LEN(CYCLE_LEN))
    u_sva (.clk, .rst_n, .start_latch, .pause_in, .reset_in, .blank_in,
    .ctrl_out, .present_value, .timing, .alarm);
`default_nettype wire

// ===== cam_timer_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Actuator model
// ----
module cam_timer_partner (
    input wire logic clk,
    input wire logic en,
    input wire logic cmd,
    output logic confirm
);
    // A working actuator confirms a cycle late; a dead one never does.
    always_ff @(posedge clk) begin
        confirm <= en & cmd;
    end
endmodule
`default_nettype wire

// ===== cam_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module cam_timer_tb;
    import cam_timer_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clear_on_power_up = 1'b1;
    logic run_on_power_up = 1'b0;
    logic output_restore_sel = 1'b1;
    logic [15:0] retained_pv = 16'h0005;
    logic [15:0] retained_out = 16'hFFFF;
    logic [255:0] on_time, off_time;
    logic start_latch = 1'b0, start_single = 1'b0, pause_in = 1'b0;
    logic reset_in = 1'b0, blank_in = 1'b0, en = 1'b1;
    logic actuator_confirm_one, timing, alarm;
    logic [15:0] ctrl_out, present_value, ev;
    int n_fail = 0, check_count = 0;
    int n_alarm = 0;
    // Clock, alarm monitor, the unit under test and the actuator model.
    always #12.5 clk = ~clk;
    always @(posedge clk) if (alarm === 1'b1) n_alarm <= n_alarm + 1;
    cam_timer #(.TICK_DIV(4), .CYCLE_LEN(8)) dut (.clk, .rst_n,
        .clear_on_power_up, .run_on_power_up, .output_restore_sel,
        .retained_pv, .retained_out, .on_time, .off_time, .start_latch,
        .start_single, .pause_in, .reset_in, .blank_in,
        .actuator_confirm_one, .ctrl_out, .present_value, .timing, .alarm);
    cam_timer_partner act (.clk, .en, .cmd(ctrl_out[0]),
        .confirm(actuator_confirm_one));
    // Expected outputs: each is on inside its own window.
    function automatic logic [15:0] eo(input logic [15:0] pv);
        logic [15:0] r;
        for (int g = 0; g < 16; g++)
            r[g] = pv >= on_time[g*16+:16] && pv < off_time[g*16+:16];
        return r;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(2);
        s = 1'b0;
        cyc(3);
    endtask
    // One tick: the value moves on, then the outputs follow it.
    task automatic step(input logic p);
        logic [15:0] last;
        last = present_value;
        for (int i = 0; i < 20 && present_value === last; i++)
            cyc(1);
        ev = (ev + 16'h0001) % 16'h0008;
        chk("pv", present_value, ev);
        pause_in = p;
        cyc(1);
        chk("out", ctrl_out, blank_in ? 16'h0000 : eo(ev));
    endtask
    task automatic power_up();
        rst_n = 1'b0;
        cyc(16);
        rst_n = 1'b1;
        cyc(6);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog against a hung wait.
    initial begin
        #(25 * 4000);
        n_fail++;
        test_done();
    end
    // Main sequence of scenarios.
    initial begin
        void'($urandom(22479));
        for (int g = 0; g < 16; g++) begin
            on_time[g*16+:16] = 16'($urandom % 9);
            off_time[g*16+:16] = 16'($urandom % 9);
        end
        on_time[15:0] = 16'h0002;
        off_time[15:0] = 16'h0005;
        power_up();
        chk("pv", present_value, 16'h0000);
        chk("timing", {15'h0000, timing}, 16'h0000);
        chk("out", ctrl_out, 16'h0000);
        pulse(start_latch);
        chk("timing", {15'h0000, timing}, 16'h0001);
        ev = 16'h0000;
        repeat (10) step(1'b0);
        chk("alarm", 16'(n_alarm), 16'h0000);
        blank_in = 1'b1;
        repeat (3) step(1'b0);
        blank_in = 1'b0;
        step(1'b0);
        step(1'b1);
        cyc(12);
        chk("pv", present_value, ev);
        chk("timing", {15'h0000, timing}, 16'h0000);
        pause_in = 1'b0;
        repeat (2) step(1'b0);
        en = 1'b0;
        repeat (9) step(1'b0);
        chk("alarm", 16'(n_alarm), 16'h0001);
        pulse(start_single);
        for (int i = 0; i < 100 && timing === 1'b1; i++)
            cyc(1);
        chk("pv", present_value, 16'h0000);
        pulse(start_single);
        pulse(start_latch);
        cyc(40);
        chk("timing", {15'h0000, timing}, 16'h0001);
        pulse(reset_in);
        chk("pv", present_value, 16'h0000);
        chk("timing", {15'h0000, timing}, 16'h0000);
        clear_on_power_up = 1'b0;
        run_on_power_up = 1'b1;
        retained_pv = 16'h0003;
        power_up();
        chk("timing", {15'h0000, timing}, 16'h0001);
        chk("pv", present_value, 16'h0003);
        clear_on_power_up = 1'b1;
        ev = 16'h0003;
        repeat (3) step(1'b0);
        clear_on_power_up = 1'b0;
        run_on_power_up = 1'b0;
        output_restore_sel = 1'b0;
        retained_pv = 16'($urandom % 8);
        retained_out = 16'($urandom);
        power_up();
        chk("pv", present_value, retained_pv);
        cyc(8);
        chk("out", ctrl_out, retained_out);
        chk("timing", {15'h0000, timing}, 16'h0000);
        pulse(reset_in);
        chk("out", ctrl_out, eo(16'h0000));
        test_done();
    end
endmodule
`default_nettype wire
